// [include/slis_pkg.sv]
/*
  constants for the per-slot level interrupt status block: register offsets,
  field positions, reset values and widths.
  assumes the device register port addresses registers by their word offset.
*/
package slis_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int          REG_W          = 16;
  localparam int          ADDR_W         = 16;
  localparam int          NUM_SLOTS      = 12;
  localparam int          FIFO_CNT_W     = 11;
  localparam logic [15:0] ADDR_DATA_STAT = 16'h0001;
  localparam logic [15:0] ADDR_LEV0_STAT = 16'h0002;
  localparam logic [15:0] ADDR_LEV1_STAT = 16'h0003;
  localparam logic [15:0] ADDR_ACLEAR    = 16'h0007;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int          FIFO_THR_BIT   = 15;
  localparam int          SLOT_L_BIT     = 11;
  localparam int          ACLR_FIFO_BIT  = 15;
  localparam int          ACLR_SLOT_L    = 11;

  // ----------------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------------
  localparam logic [11:0] STATUS_RST     = 12'h000;
  localparam logic [15:0] ACLEAR_RST     = 16'h8FFF;
  localparam logic [15:0] ACLEAR_MASK    = 16'h8FFF;
  localparam logic [15:0] RDATA_RST      = 16'h0000;

endpackage : slis_pkg

// [rtl/slis_flag_bank.sv]
/*
  bank of sticky event flags: hardware set, clear by request, set wins.
  assumes set and clear are synchronous one-cycle pulses on i_clk.
*/
`timescale 1ns/1ps
module slis_flag_bank #(
  parameter int WIDTH = 12
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clr,
  output logic      [WIDTH-1:0] o_flag
);

  // ----------------------------------------------------------------------
  // one flop per flag
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_flag
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          o_flag[g] <= 1'b0;
        else if (i_ce)
        begin
          // set listed last so a same-cycle clear never loses an event
          if (i_clr[g])
            o_flag[g] <= 1'b0;
          if (i_set[g])
            o_flag[g] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule : slis_flag_bank

// [rtl/slis_irq_status.sv]
/*
  per-slot level interrupt status, fifo threshold and slot l data-ready flags,
  and the interrupt autoclear enable register.
  assumes all event inputs are synchronous pulses and the register port
  strobes last one cycle each.
*/
// Summary of operation
// RQ1: the level-zero status register holds one flag per slot, a at bit 0 to l at bit 11, 15:12 read 0.
// RQ2: a level-zero flag sets on its slot's data update when the level-zero criteria hold.
// RQ3: level-zero flags reset to 0 and clear when software writes one, a zero leaves them.
// RQ4: the level-one status register has the same layout, bits 15:12 reading 0.
// RQ5: a level-one flag sets on its slot's data update when the level-one criteria hold.
// RQ6: level-one flags reset to 0 and clear only by a written one.
// RQ7: autoclear bit 15 resets to 1 and then a fifo read clears the threshold flag; 14:12 read 0.
// RQ8: autoclear bit 11 resets to 1 and then a slot l data read clears the slot l data flag.
// RQ9: software may change both autoclear bits to pick read clearing or write-one clearing.
// RQ10: the slot l data flag sets on every slot l data update, cleared by write one or autoclear.
// RQ11: the fifo threshold flag sets on a fifo write when the byte count exceeds the threshold.
// RQ12: a set and a clear of the same flag in one cycle leave the flag set.
`timescale 1ns/1ps
module slis_irq_status #(
  parameter int NUM_SLOTS = slis_pkg::NUM_SLOTS,
  parameter int CNT_W     = slis_pkg::FIFO_CNT_W
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  input  wire logic                      i_ce,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [slis_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [slis_pkg::REG_W-1:0]  i_reg_wdata,
  input  wire logic [NUM_SLOTS-1:0]      i_slot_update,
  input  wire logic [NUM_SLOTS-1:0]      i_lev0_met,
  input  wire logic [NUM_SLOTS-1:0]      i_lev1_met,
  input  wire logic                      i_fifo_write,
  input  wire logic                      i_fifo_read,
  input  wire logic [CNT_W-1:0]          i_fifo_byte_count,
  input  wire logic [CNT_W-1:0]          i_fifo_threshold_value,
  input  wire logic                      i_slot_l_data_read,
  output logic      [slis_pkg::REG_W-1:0]  o_reg_rdata,
  output logic      [NUM_SLOTS-1:0]      o_level_zero_irq_status,
  output logic      [NUM_SLOTS-1:0]      o_level_one_irq_status,
  output logic                           o_fifo_threshold_flag,
  output logic                           o_slot_l_data_flag,
  output logic                           o_fifo_threshold_autoclear_en,
  output logic                           o_slot_l_data_autoclear_en
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [slis_pkg::ADDR_W-1:0] addr,
                                   input logic [slis_pkg::ADDR_W-1:0] target);
    reg_hit = (addr == target);
  endfunction : reg_hit

  logic                       wr_lev0;
  logic                       wr_lev1;
  logic                       wr_data;
  logic                       wr_aclr;
  logic [slis_pkg::REG_W-1:0] irq_autoclear_enable;
  logic [NUM_SLOTS-1:0]       set_lev0;
  logic [NUM_SLOTS-1:0]       set_lev1;
  logic                       set_fifo_thr;
  logic                       set_slot_l;
  logic                       clr_fifo_thr;
  logic                       clr_slot_l;
  logic [slis_pkg::REG_W-1:0] next_rdata;

  assign wr_lev0 = i_reg_wr && reg_hit(i_reg_addr, slis_pkg::ADDR_LEV0_STAT);
  assign wr_lev1 = i_reg_wr && reg_hit(i_reg_addr, slis_pkg::ADDR_LEV1_STAT);
  assign wr_data = i_reg_wr && reg_hit(i_reg_addr, slis_pkg::ADDR_DATA_STAT);
  assign wr_aclr = i_reg_wr && reg_hit(i_reg_addr, slis_pkg::ADDR_ACLEAR);

  // ----------------------------------------------------------------------
  // level flag events
  // ----------------------------------------------------------------------
  assign set_lev0 = i_slot_update & i_lev0_met;                           // [RQ2]
  assign set_lev1 = i_slot_update & i_lev1_met;                           // [RQ5]

  slis_flag_bank #(
    .WIDTH (NUM_SLOTS)
  ) u_lev0 (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_set  (set_lev0),
    .i_clr  (wr_lev0 ? i_reg_wdata[NUM_SLOTS-1:0] : '0),                  // [RQ3] [RQ12]
    .o_flag (o_level_zero_irq_status)
  );

  slis_flag_bank #(
    .WIDTH (NUM_SLOTS)
  ) u_lev1 (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_set  (set_lev1),
    .i_clr  (wr_lev1 ? i_reg_wdata[NUM_SLOTS-1:0] : '0),                  // [RQ6] [RQ12]
    .o_flag (o_level_one_irq_status)
  );

  // ----------------------------------------------------------------------
  // fifo threshold and slot l data flags
  // ----------------------------------------------------------------------
  assign set_fifo_thr = i_fifo_write && (i_fifo_byte_count > i_fifo_threshold_value); // [RQ11]
  assign set_slot_l   = i_slot_update[NUM_SLOTS-1];                                    // [RQ10]
  assign clr_fifo_thr = (wr_data && i_reg_wdata[slis_pkg::FIFO_THR_BIT])
                      || (i_fifo_read && o_fifo_threshold_autoclear_en);              // [RQ7]
  assign clr_slot_l   = (wr_data && i_reg_wdata[slis_pkg::SLOT_L_BIT])
                      || (i_slot_l_data_read && o_slot_l_data_autoclear_en);          // [RQ8]

  slis_flag_bank #(
    .WIDTH (2)
  ) u_data (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_set  ({set_fifo_thr, set_slot_l}),
    .i_clr  ({clr_fifo_thr, clr_slot_l}),                                 // [RQ12]
    .o_flag ({o_fifo_threshold_flag, o_slot_l_data_flag})
  );

  // ----------------------------------------------------------------------
  // autoclear enable register
  // ----------------------------------------------------------------------
  // bits 10:0 are kept as plain storage and drive no autoclear in this block
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_autoclear_enable <= slis_pkg::ACLEAR_RST;                       // [RQ7] [RQ8]
    else if (i_ce && wr_aclr)
      irq_autoclear_enable <= i_reg_wdata & slis_pkg::ACLEAR_MASK;        // [RQ9]
  end

  assign o_fifo_threshold_autoclear_en = irq_autoclear_enable[slis_pkg::ACLR_FIFO_BIT];
  assign o_slot_l_data_autoclear_en    = irq_autoclear_enable[slis_pkg::ACLR_SLOT_L];

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rdata = slis_pkg::RDATA_RST;
    if (reg_hit(i_reg_addr, slis_pkg::ADDR_LEV0_STAT))
      next_rdata[NUM_SLOTS-1:0] = o_level_zero_irq_status;                // [RQ1]
    else if (reg_hit(i_reg_addr, slis_pkg::ADDR_LEV1_STAT))
      next_rdata[NUM_SLOTS-1:0] = o_level_one_irq_status;                 // [RQ4]
    else if (reg_hit(i_reg_addr, slis_pkg::ADDR_DATA_STAT))
    begin
      next_rdata[slis_pkg::FIFO_THR_BIT] = o_fifo_threshold_flag;
      next_rdata[slis_pkg::SLOT_L_BIT]  = o_slot_l_data_flag;
    end
    else if (reg_hit(i_reg_addr, slis_pkg::ADDR_ACLEAR))
      next_rdata = irq_autoclear_enable;
  end

  // read data holds until the next read strobe
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_reg_rdata <= slis_pkg::RDATA_RST;
    else if (i_ce && i_reg_rd)
      o_reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_lev0_w1c;
    i_ce && wr_lev0 && ((i_reg_wdata[NUM_SLOTS-1:0] & set_lev0) == '0);
  endsequence
  sequence s_lev1_w1c;
    i_ce && wr_lev1 && ((i_reg_wdata[NUM_SLOTS-1:0] & set_lev1) == '0);
  endsequence

  lev0_set_a: assert property (i_ce && (set_lev0 != '0) |=>                      // [RQ2]
      ((o_level_zero_irq_status & $past(set_lev0)) == $past(set_lev0)))
    else $error("level zero flag missed its set");
  lev0_clear_a: assert property (s_lev0_w1c |=>                                  // [RQ3]
      ((o_level_zero_irq_status & $past(i_reg_wdata[NUM_SLOTS-1:0])) == '0))
    else $error("level zero flag not cleared by write one");
  lev0_cause_a: assert property (i_ce |=>                                        // [RQ2]
      ((o_level_zero_irq_status & ~$past(o_level_zero_irq_status)
        & ~$past(set_lev0)) == '0))
    else $error("level zero flag rose without a set");
  lev1_set_a: assert property (i_ce && (set_lev1 != '0) |=>                      // [RQ5]
      ((o_level_one_irq_status & $past(set_lev1)) == $past(set_lev1)))
    else $error("level one flag missed its set");
  lev1_clear_a: assert property (s_lev1_w1c |=>                                  // [RQ6]
      ((o_level_one_irq_status & $past(i_reg_wdata[NUM_SLOTS-1:0])) == '0))
    else $error("level one flag not cleared by write one");
  lev1_zero_keep_a: assert property (i_ce && wr_lev1 && !i_reg_wdata[0]          // [RQ6]
      && o_level_one_irq_status[0] |=> o_level_one_irq_status[0])
    else $error("written zero changed a level one flag");
  reserved_read_a: assert property (i_ce && i_reg_rd                            // [RQ1] [RQ4]
      && (reg_hit(i_reg_addr, slis_pkg::ADDR_LEV0_STAT)
       || reg_hit(i_reg_addr, slis_pkg::ADDR_LEV1_STAT)) |=> (o_reg_rdata[15:12] == 4'h0))
    else $error("reserved status bits read nonzero");
  fifo_autoclr_a: assert property (i_ce && i_fifo_read && o_fifo_threshold_autoclear_en  // [RQ7]
      && !set_fifo_thr |=> !o_fifo_threshold_flag)
    else $error("fifo read did not autoclear threshold flag");
  slot_l_autoclr_a: assert property (i_ce && i_slot_l_data_read                  // [RQ8]
      && o_slot_l_data_autoclear_en && !set_slot_l |=> !o_slot_l_data_flag)
    else $error("slot l read did not autoclear data flag");
  slot_l_set_a: assert property (i_ce && set_slot_l ##1 !i_ce [*2]               // [RQ10]
      |-> o_slot_l_data_flag)
    else $error("slot l data flag not set on update");
  fifo_thr_set_a: assert property (i_ce && set_fifo_thr |=> o_fifo_threshold_flag) // [RQ11]
    else $error("fifo threshold flag not set");
  set_wins_a: assert property (i_ce && set_lev0[0] && wr_lev0 && i_reg_wdata[0]  // [RQ12]
      |=> o_level_zero_irq_status[0])
    else $error("clear beat a same-cycle set");

endmodule : slis_irq_status

// [verification/slis_irq_status_tb_top.sv]
/*
  self-checking bench for slis_irq_status: reset values, level events,
  write-one clearing, fifo threshold and slot l data flags, autoclear control.
  assumes the strobe register port and one-cycle event pulses of the block.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module slis_irq_status_tb_top;
  // ----------------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------------
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1;
  logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000, i_reg_wdata = 16'h0000;
  logic [11:0] i_slot_update = 12'h000, i_lev0_met = 12'h000, i_lev1_met = 12'h000;
  logic        i_fifo_write = 1'b0, i_fifo_read = 1'b0, i_slot_l_data_read = 1'b0;
  logic [10:0] i_fifo_byte_count = 11'h000, i_fifo_threshold_value = 11'h000;
  logic [15:0] o_reg_rdata;
  logic [11:0] o_level_zero_irq_status, o_level_one_irq_status;
  logic        o_fifo_threshold_flag, o_slot_l_data_flag;
  logic        o_fifo_threshold_autoclear_en, o_slot_l_data_autoclear_en;
  logic [15:0] exp_q[$];
  logic [15:0] lf = 16'h0020, w, ex;
  logic [11:0] e0 = 12'h000, e1 = 12'h000;
  logic        rd_seen = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  int          n_fail = 0, checks = 0;

  always #25 i_clk = ~i_clk;

  slis_irq_status u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_slot_update(i_slot_update), .i_lev0_met(i_lev0_met), .i_lev1_met(i_lev1_met),
    .i_fifo_write(i_fifo_write), .i_fifo_read(i_fifo_read),
    .i_fifo_byte_count(i_fifo_byte_count), .i_fifo_threshold_value(i_fifo_threshold_value),
    .i_slot_l_data_read(i_slot_l_data_read), .o_reg_rdata(o_reg_rdata),
    .o_level_zero_irq_status(o_level_zero_irq_status),
    .o_level_one_irq_status(o_level_one_irq_status),
    .o_fifo_threshold_flag(o_fifo_threshold_flag), .o_slot_l_data_flag(o_slot_l_data_flag),
    .o_fifo_threshold_autoclear_en(o_fifo_threshold_autoclear_en),
    .o_slot_l_data_autoclear_en(o_slot_l_data_autoclear_en));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // read data lands one cycle after the taken read, so the note waits there
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
  endtask : wr

  // f = {fifo write, fifo read, slot l data read}
  task automatic evt(input logic [15:0] u, input logic [15:0] m0, input logic [15:0] m1,
                     input logic [2:0] f);
    @(posedge i_clk);
    i_slot_update <= u[11:0];
    i_lev0_met    <= m0[11:0];
    i_lev1_met    <= m1[11:0];
    {i_fifo_write, i_fifo_read, i_slot_l_data_read} <= f;
    e0 = e0 | (u[11:0] & m0[11:0]);
    e1 = e1 | (u[11:0] & m1[11:0]);
    @(posedge i_clk);
    i_slot_update <= 12'h000;
    {i_fifo_write, i_fifo_read, i_slot_l_data_read} <= 3'b000;
  endtask : evt

  // ----------------------------------------------------------------------
  // result watcher: oldest note against each read answer
  // ----------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    rd_seen <= i_reg_rd & i_ce;
    rd_addr <= i_reg_addr;
    if (rd_seen)
    begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      `CHK(o_reg_rdata, ex)
      // the level outputs must agree with the register view of the same note
      case (rd_addr)
        16'h0001: `CHK({o_fifo_threshold_flag, o_slot_l_data_flag}, {ex[15], ex[11]})
        16'h0002: `CHK(o_level_zero_irq_status, ex[11:0])
        16'h0003: `CHK(o_level_one_irq_status, ex[11:0])
        16'h0007: `CHK({o_fifo_threshold_autoclear_en, o_slot_l_data_autoclear_en}, {ex[15], ex[11]})
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(16'h0002, 16'h0000);
    rd(16'h0003, 16'h0000);
    rd(16'h0007, 16'h8fff);
    rd(16'h0004, 16'h0000);
    repeat (8) evt(rnd(), rnd(), rnd(), 3'b000);
    rd(16'h0002, {4'h0, e0});
    rd(16'h0003, {4'h0, e1});
    w = rnd() | 16'hf000;
    wr(16'h0002, w);
    e0 = e0 & ~w[11:0];
    w = rnd();
    wr(16'h0003, w);
    e1 = e1 & ~w[11:0];
    rd(16'h0002, {4'h0, e0});
    rd(16'h0003, {4'h0, e1});
    // clear and set of slot a in one cycle: set must survive
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= 16'h0002;
    i_reg_wdata <= 16'hffff;
    i_slot_update <= 12'h001;
    i_lev0_met <= 12'h001;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_slot_update <= 12'h000;
    rd(16'h0002, 16'h0001);
    wr(16'h0001, 16'h8800);
    w = rnd();
    i_fifo_threshold_value <= {1'b0, w[9:0]};
    i_fifo_byte_count <= {1'b0, w[9:0]};
    evt(16'h0000, 16'h0000, 16'h0000, 3'b100);
    rd(16'h0001, 16'h0000);
    i_fifo_byte_count <= {1'b0, w[9:0]} + 11'h001;
    evt(16'h0800, 16'h0000, 16'h0000, 3'b100);
    rd(16'h0001, 16'h8800);
    evt(16'h0000, 16'h0000, 16'h0000, 3'b011);
    rd(16'h0001, 16'h0000);
    wr(16'h0007, 16'h7000);
    rd(16'h0007, 16'h0000);
    evt(16'h0800, 16'h0000, 16'h0000, 3'b100);
    evt(16'h0000, 16'h0000, 16'h0000, 3'b011);
    rd(16'h0001, 16'h8800);
    wr(16'h0001, 16'h8800);
    rd(16'h0001, 16'h0000);
    wr(16'h0007, 16'h8800);
    rd(16'h0007, 16'h8800);
    // slot l update, then two frozen cycles carrying a clear and an autoclear read
    evt(16'h0800, 16'h0000, 16'h0000, 3'b000);
    i_ce               <= 1'b0;
    i_reg_wr           <= 1'b1;
    i_reg_addr         <= 16'h0001;
    i_reg_wdata        <= 16'h8800;
    i_slot_l_data_read <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_ce               <= 1'b1;
    i_reg_wr           <= 1'b0;
    i_slot_l_data_read <= 1'b0;
    rd(16'h0001, 16'h0800);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++)
      @(posedge i_clk);
    if (exp_q.size() > 0)
      n_fail++;
    finish_test();
  end

  // hang guard
  initial
  begin
    #100_000;
    n_fail++;
    finish_test();
  end
endmodule : slis_irq_status_tb_top
